// *** include/retstack_pkg.sv ***
// package: constants for the return-stack sequencer
// assumes a single clock, synchronous active-high reset
// Function
// [RULE1] call: pc+1, sp-1, save pc+1 at new sp, load operand into pc
// [RULE2] exit: load pc from entry at sp, then increment sp
// [RULE3] after exit-then-skip, first instruction at return address acts as no-op
// [RULE4] fetch cycle one: pc+1, sp-1, save it, load pc from table address
// [RULE5] fetch cycle two: program word to data buffer, restore pc, sp+1
// [RULE6] stack pointer is a three-bit wrapping counter over eight entries
// [RULE7] eighth entry has no storage; writes lost, reads undefined
// [RULE8] stack pointer becomes seven on power-on, chip-enable reset, clock stop
package retstack_pkg;
   localparam int unsigned PC_WIDTH = 13;
   localparam int unsigned SP_WIDTH = 3;
   localparam int unsigned DATA_WIDTH = 16;
   localparam logic [SP_WIDTH-1:0] SP_RESET = 3'h7;
   localparam logic [SP_WIDTH-1:0] SP_MISSING = 3'h7;
   localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
   localparam logic [DATA_WIDTH-1:0] DBF_RESET = 16'h0000;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_CALL,
      OP_EXIT,
      OP_EXIT_SKIP,
      OP_FETCH
   } op_e;
   typedef enum logic {
      ST_RUN,
      ST_FETCH2
   } seq_e;
endpackage : retstack_pkg

// *** rtl/return_stack_ram.sv ***
// seven-entry return stack memory, registered read
// assumes index 7 is the missing entry
`timescale 1ns/100ps
`default_nettype none
module return_stack_ram
   import retstack_pkg::*;
#(
   parameter int unsigned WIDTH = PC_WIDTH
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [SP_WIDTH-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [SP_WIDTH-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [0:6];
   always_ff @(posedge clock) begin
      if (wr_en && wr_idx != SP_MISSING) begin // see [RULE7]
         mem[wr_idx] <= wr_data;
      end
      // missing entry reads as the last word driven, i.e. undefined to software
      if (rd_idx != SP_MISSING) begin // see [RULE7]
         // same entry written and read in one cycle: pass the new word straight through
         if (wr_en && wr_idx == rd_idx) begin
            rd_data <= wr_data;
         end else begin
            rd_data <= mem[rd_idx];
         end
      end
   end
endmodule : return_stack_ram
`default_nettype wire

// *** rtl/return_stack_sequencer.sv ***
// return-stack sequencer: pc, stack pointer, stack, table fetch
// assumes decoder presents one op per cycle while ready is high
`timescale 1ns/100ps
`default_nettype none
module return_stack_sequencer
   import retstack_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce_reset,
   input wire logic clock_stop,
   input wire logic op_valid,
   input wire op_e op,
   input wire logic [PC_WIDTH-1:0] call_operand,
   input wire logic [PC_WIDTH-1:0] table_address_reg,
   input wire logic [DATA_WIDTH-1:0] prog_word,
   output logic ready,
   output logic [PC_WIDTH-1:0] pc_q,
   output logic [SP_WIDTH-1:0] stack_pointer_q,
   output logic [DATA_WIDTH-1:0] data_buffer_reg_q,
   output logic skip_q
);
   seq_e state_q, state_d;
   logic [PC_WIDTH-1:0] pc_d;
   logic [SP_WIDTH-1:0] sp_d;
   logic [DATA_WIDTH-1:0] dbf_d;
   logic skip_d;
   logic pop_pend_q, pop_pend_d;
   logic wr_en;
   logic [SP_WIDTH-1:0] wr_idx;
   logic [PC_WIDTH-1:0] entry_rd;
   logic [PC_WIDTH-1:0] pc_inc;
   logic go;
   // shadow of the latest push, so a restore can be checked without a second stack
   logic [PC_WIDTH-1:0] push_val_q, push_val_d;
   logic [SP_WIDTH-1:0] push_idx_q, push_idx_d;
   logic push_seen_q, push_seen_d;
   logic restore;

   // exits take an extra cycle for the registered stack read
   assign ready = (state_q == ST_RUN) && !pop_pend_q;
   assign go = op_valid && ready;
   assign pc_inc = pc_q + 13'h0001;
   assign restore = pop_pend_q || (state_q == ST_FETCH2);

   return_stack_ram #(.WIDTH(PC_WIDTH)) u_ram (
      .clock(clock),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(pc_inc),
      // next pointer, so the entry it selects stands in rd_data one cycle on
      .rd_idx(sp_d),
      .rd_data(entry_rd)
   );

   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      sp_d = stack_pointer_q;
      dbf_d = data_buffer_reg_q;
      skip_d = skip_q;
      pop_pend_d = 1'b0;
      wr_en = 1'b0;
      wr_idx = stack_pointer_q - 3'h1; // see [RULE6]
      case (state_q)
         ST_RUN: begin
            if (pop_pend_q) begin
               pc_d = entry_rd; // see [RULE2]
               sp_d = stack_pointer_q + 3'h1; // see [RULE2] [RULE6]
            end else if (go) begin
               if (skip_q) begin
                  skip_d = 1'b0; // see [RULE3]
                  pc_d = pc_inc;
               end else begin
                  case (op)
                     OP_CALL: begin
                        sp_d = wr_idx; // see [RULE1]
                        wr_en = 1'b1;
                        pc_d = call_operand;
                     end
                     OP_EXIT: pop_pend_d = 1'b1;
                     OP_EXIT_SKIP: begin
                        pop_pend_d = 1'b1;
                        skip_d = 1'b1; // see [RULE3]
                     end
                     OP_FETCH: begin
                        sp_d = wr_idx; // see [RULE4]
                        wr_en = 1'b1;
                        pc_d = table_address_reg;
                        state_d = ST_FETCH2;
                     end
                     default: pc_d = pc_inc;
                  endcase
               end
            end
         end
         ST_FETCH2: begin
            // stack read issued last cycle is ready now
            dbf_d = prog_word; // see [RULE5]
            pc_d = entry_rd;
            sp_d = stack_pointer_q + 3'h1;
            state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
      if (ce_reset || clock_stop) begin
         sp_d = SP_RESET; // see [RULE8]
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_RUN;
         pc_q <= PC_RESET;
         stack_pointer_q <= SP_RESET; // see [RULE8]
         data_buffer_reg_q <= DBF_RESET;
         skip_q <= 1'b0;
         pop_pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_q <= pc_d;
         stack_pointer_q <= sp_d;
         data_buffer_reg_q <= dbf_d;
         skip_q <= skip_d;
         pop_pend_q <= pop_pend_d;
      end
   end

   always_comb begin
      push_val_d = push_val_q;
      push_idx_d = push_idx_q;
      push_seen_d = push_seen_q;
      if (wr_en) begin
         push_val_d = pc_inc;
         push_idx_d = wr_idx;
         push_seen_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         push_val_q <= PC_RESET;
         push_idx_q <= SP_RESET;
         push_seen_q <= 1'b0;
      end else begin
         push_val_q <= push_val_d;
         push_idx_q <= push_idx_d;
         push_seen_q <= push_seen_d;
      end
   end

   call_push_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE1]
      go && !skip_q && op == OP_CALL |=> stack_pointer_q == $past(stack_pointer_q) - 3'h1
      && pc_q == $past(call_operand)) else $error("call did not push");

   exit_wait_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE2]
      go && !skip_q && (op == OP_EXIT || op == OP_EXIT_SKIP) |=> !ready && pc_q == $past(pc_q)
      && stack_pointer_q == $past(stack_pointer_q)) else $error("exit moved state too early");

   exit_pop_a: assert property (@(posedge clock) disable iff (rst) // see [RULE2]
      pop_pend_q && !ce_reset && !clock_stop |=> stack_pointer_q == $past(stack_pointer_q) + 3'h1)
      else $error("exit did not pop");

   restore_pc_a: assert property (@(posedge clock) disable iff (rst) // see [RULE2]
      restore && push_seen_q && stack_pointer_q == push_idx_q && push_idx_q != SP_MISSING
      |=> pc_q == $past(push_val_q)) else $error("restored pc is not the pushed address");

   skip_set_a: assert property (@(posedge clock) disable iff (rst) // see [RULE3]
      go && !skip_q && op == OP_EXIT_SKIP |=> skip_q)
      else $error("exit then skip did not arm the skip");

   skip_nop_a: assert property (@(posedge clock) disable iff (rst) // see [RULE3]
      skip_q && go |=> !skip_q && pc_q == $past(pc_q) + 13'h0001 && state_q == ST_RUN)
      else $error("skipped instruction had effect");

   skip_quiet_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE3]
      skip_q && go |=> stack_pointer_q == $past(stack_pointer_q) && ready)
      else $error("skipped instruction moved the stack");

   fetch_one_a: assert property (@(posedge clock) disable iff (rst) // see [RULE4]
      go && !skip_q && op == OP_FETCH |=> state_q == ST_FETCH2 && pc_q == $past(table_address_reg))
      else $error("fetch first cycle wrong");

   fetch_push_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE4]
      go && !skip_q && op == OP_FETCH |=> stack_pointer_q == $past(stack_pointer_q) - 3'h1)
      else $error("fetch did not push");

   fetch_two_a: assert property (@(posedge clock) disable iff (rst) // see [RULE5]
      state_q == ST_FETCH2 |=> data_buffer_reg_q == $past(prog_word) && ready)
      else $error("fetch second cycle wrong");

   fetch_round_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE5]
      go && !skip_q && op == OP_FETCH && stack_pointer_q != 3'h0 |=> ##1
      stack_pointer_q == $past(stack_pointer_q, 2) && pc_q == $past(pc_q, 2) + 13'h0001)
      else $error("fetch did not return");

   dbf_hold_a: assert property (@(posedge clock) disable iff (rst) // see [RULE5]
      state_q != ST_FETCH2 |=> data_buffer_reg_q == $past(data_buffer_reg_q))
      else $error("data buffer changed outside a fetch");

   wrap_a: assert property (@(posedge clock) disable iff (rst || ce_reset || clock_stop) // see [RULE6]
      go && !skip_q && op == OP_CALL && stack_pointer_q == 3'h0 |=> stack_pointer_q == 3'h7)
      else $error("pointer did not wrap");

   step_a: assert property (@(posedge clock) disable iff (rst) // see [RULE6]
      !rst && !ce_reset && !clock_stop |=> stack_pointer_q == $past(stack_pointer_q)
      || stack_pointer_q == $past(stack_pointer_q) + 3'h1
      || stack_pointer_q == $past(stack_pointer_q) - 3'h1) else $error("pointer jumped");

   missing_read_a: assert property (@(posedge clock) disable iff (rst) // see [RULE7]
      pop_pend_q && stack_pointer_q == SP_MISSING |-> entry_rd == $past(entry_rd))
      else $error("missing entry returned a stored word");

   sp_reset_a: assert property (@(posedge clock) // see [RULE8]
      rst || ce_reset || clock_stop |=> stack_pointer_q == SP_RESET)
      else $error("pointer not seven after reset");

   // covers: the main ways through the sequencer
   call_c: cover property (@(posedge clock) go && op == OP_CALL);
   exit_skip_c: cover property (@(posedge clock) go && op == OP_EXIT_SKIP ##[2:3] go && skip_q);
   fetch_c: cover property (@(posedge clock) state_q == ST_FETCH2);
   wrap_c: cover property (@(posedge clock) go && !skip_q && op == OP_CALL && stack_pointer_q == 3'h0);
   missing_pop_c: cover property (@(posedge clock) pop_pend_q && stack_pointer_q == SP_MISSING);
endmodule : return_stack_sequencer
`default_nettype wire

// *** bench/testbench.sv ***
// bench: corner and random op streams checked against a reference stack model
// assumes the sequencer alone, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import retstack_pkg::*;
   logic clock, rst, ce_reset, clock_stop, op_valid, ready, skip_q, skip, skipped, pc_known;
   op_e op;
   logic [PC_WIDTH-1:0] call_operand, table_address_reg, pc_q, pc, ret;
   logic [PC_WIDTH-1:0] stk [7];
   logic [SP_WIDTH-1:0] stack_pointer_q, sp;
   logic [DATA_WIDTH-1:0] prog_word, data_buffer_reg_q, dbf;
   logic [31:0] r;
   int seed = 49076;
   int n_fail = 0;
   int n_compared = 0;
   return_stack_sequencer DUT (.clock(clock), .rst(rst), .ce_reset(ce_reset), .clock_stop(clock_stop),
      .op_valid(op_valid), .op(op), .call_operand(call_operand), .table_address_reg(table_address_reg),
      .prog_word(prog_word), .ready(ready), .pc_q(pc_q), .stack_pointer_q(stack_pointer_q),
      .data_buffer_reg_q(data_buffer_reg_q), .skip_q(skip_q));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic check_all;
      chk(stack_pointer_q, sp);
      if (pc_known)
         chk(pc_q, pc);
      chk(data_buffer_reg_q, dbf);
      chk(skip_q, skip);
   endtask : check_all
   task automatic run_op(input op_e o);
      int i;
      @(posedge clock);
      r = $random(seed);
      op_valid <= 1'b1;
      op <= o;
      call_operand <= r[PC_WIDTH-1:0];
      table_address_reg <= r[31:19];
      prog_word <= r[31:16] ^ r[15:0];
      @(posedge clock);
      op_valid <= 1'b0;
      // model: skipped op only advances pc, entry 7 holds nothing
      ret = pc + 1'b1;
      skipped = skip;
      skip = 1'b0;
      if (skipped || o == OP_NONE)
         pc = ret;
      else if (o == OP_CALL || o == OP_FETCH) begin
         sp = sp - 1'b1;
         if (sp != SP_MISSING)
            stk[sp] = ret;
         pc = call_operand;
         if (o == OP_CALL)
            pc_known = 1'b1;
      end
      if (!skipped && (o == OP_FETCH || o == OP_EXIT || o == OP_EXIT_SKIP)) begin
         if (o == OP_FETCH)
            dbf = prog_word;
         pc_known = (sp != SP_MISSING);
         if (pc_known)
            pc = stk[sp];
         sp = sp + 1'b1;
         skip = (o == OP_EXIT_SKIP);
      end
      i = 0;
      do begin
         @(negedge clock);
         i++;
         if (i == 1 && o == OP_FETCH && !skipped)
            chk(pc_q, table_address_reg);
      end while (ready !== 1'b1 && i < 5);
      if (ready !== 1'b1) begin
         n_fail++;
         end_of_test();
      end else begin
         check_all();
      end
   endtask : run_op
   task automatic stack_reset(input logic stop);
      @(posedge clock);
      ce_reset <= !stop;
      clock_stop <= stop;
      @(posedge clock);
      ce_reset <= 1'b0;
      clock_stop <= 1'b0;
      sp = SP_RESET;
      @(negedge clock);
      check_all();
   endtask : stack_reset
   initial begin
      rst = 1'b1;
      ce_reset = 1'b0;
      clock_stop = 1'b0;
      op_valid = 1'b0;
      op = OP_NONE;
      call_operand = '0;
      table_address_reg = '0;
      prog_word = '0;
      pc = PC_RESET;
      sp = SP_RESET;
      dbf = DBF_RESET;
      skip = 1'b0;
      pc_known = 1'b1;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check_all();
      $display("reset test done");
      // nine deep wraps past the missing entry, then unwinds
      repeat (9) run_op(OP_CALL);
      repeat (9) run_op(OP_EXIT);
      run_op(OP_CALL);
      run_op(OP_FETCH);
      run_op(OP_EXIT_SKIP);
      run_op(OP_CALL);
      stack_reset(1'b0);
      stack_reset(1'b1);
      $display("corner test done");
      for (int k = 0; k < 400; k++) begin
         r = $random(seed);
         run_op(op_e'(3'(r % 5)));
         if (k % 50 == 49)
            stack_reset(r[3]);
      end
      $display("random test done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
